// File: src/ipc_top.sv
// Interrupt priority block: priority selectors, reset-cause register, external pin,
// timer-zero and port-B change interrupts, wake logic and context save on entry.
// Assumes an APB master on pclk; core signals are synchronous to pclk.
// Functional notes
// RULE_01: Capture channels 10..4 priority in bits 7..1
// RULE_02: Bit 0 selects enhanced capture three priority
// RULE_03: Second selector register holds six timer priorities
// RULE_04: Top two selector bits ignore writes, zero
// RULE_05: Priority enable bit splits high and low
// RULE_06: Reset control bit six reads zero
// RULE_07: Reset cause flags in bits five to zero
// RULE_08: Edge select picks rising or falling edge
// RULE_09: Selected edge sets flag; enable gates request
// RULE_10: Software clears pin flag before re-enabling
// RULE_11: Pin interrupts wake if enabled before entry
// RULE_12: Deep sleep wakes from pin zero, reset
// RULE_13: Pins one to three priority bit placement
// RULE_14: Pin zero always high priority
// RULE_15: Eight-bit timer wrap sets timer flag
// RULE_16: Sixteen-bit timer wrap sets timer flag
// RULE_17: Timer enable and priority bit placement
// RULE_18: Port-B upper change sets change flag
// RULE_19: Entry pushes return address, shadows context
// RULE_20: Software saves context without fast return
// RULE_21: Peripheral priorities ignored unless levels enabled
// RULE_22: Flag and enable raise routed request
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "ipc_map.svh"
module ipc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] ext_irq_pin,
	input wire logic [3:0] port_b_pin,
	input wire logic [13:0] periph_pending,
	input wire logic sleep_mode,
	input wire logic idle_mode,
	input wire logic deep_sleep_mode,
	input wire logic irq_taken,
	input wire logic ret_pop,
	input wire logic [20:0] pc_in,
	input wire logic [7:0] working_register_in,
	input wire logic [7:0] status_in,
	input wire logic [7:0] bank_select_register_in,
	output logic irq_high,
	output logic irq_low,
	output logic wake_req,
	output logic wake_to_reset_vector,
	output logic [20:0] return_pc,
	output logic [7:0] shadow_working_register,
	output logic [7:0] shadow_status,
	output logic [7:0] shadow_bank_select,
	output logic [4:0] stack_depth
);
	ipc_pkg::ipc_state_t s_q;
	ipc_pkg::ipc_state_t s_d;
	logic [20:0] stack_mem [0:30];
	logic [3:0] ext_rise;
	logic [3:0] ext_fall;
	logic [3:0] ext_evt;
	logic [3:0] pb_rise;
	logic [3:0] pb_fall;
	logic pb_change;
	logic setup;
	logic wr;
	logic addr_ok;
	logic [11:0] idx;
	logic hit_cap, hit_tmr, hit_rst, hit_main, hit_second, hit_third, hit_t0c, hit_t0n;
	logic hit_any;
	logic [7:0] rd_byte;
	logic t0_wrap8, t0_wrap16, t0_wrap;
	logic [5:0] core_act;
	logic [5:0] core_prio;
	logic [13:0] periph_prio;
	logic hi_pend, lo_pend, any_core, any_periph;
	logic push, pop;
	logic [4:0] sp_less2;

	// ****************************************
	// Pin conditioning
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pins
			ipc_pin u_ext (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.pin(ext_irq_pin[gi]),
				.stable(),
				.rise(ext_rise[gi]),
				.fall(ext_fall[gi])
			);
			ipc_pin u_pb (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.pin(port_b_pin[gi]),
				.stable(),
				.rise(pb_rise[gi]),
				.fall(pb_fall[gi])
			);
			// RULE_08: edge select per pin
			assign ext_evt[gi] = s_q.second_ctrl[`IPC_SECOND_EDGE0 - gi] ? ext_rise[gi] :
				ext_fall[gi];
		end
	endgenerate

	// RULE_18: any upper port-B change
	assign pb_change = |(pb_rise | pb_fall);

	// ****************************************
	// APB decode
	// ****************************************
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite & ce;
	assign idx = paddr[13:2];
	assign addr_ok = (paddr[15:14] == 2'h0) && (paddr[1:0] == 2'h0);
	assign hit_cap = addr_ok && (idx == `IPC_IDX_CAP_PRIO);
	assign hit_tmr = addr_ok && (idx == `IPC_IDX_TMR_PRIO);
	assign hit_rst = addr_ok && (idx == `IPC_IDX_RST_CTRL);
	assign hit_main = addr_ok && (idx == `IPC_IDX_MAIN_CTRL);
	assign hit_second = addr_ok && (idx == `IPC_IDX_SECOND_CTRL);
	assign hit_third = addr_ok && (idx == `IPC_IDX_THIRD_CTRL);
	assign hit_t0c = addr_ok && (idx == `IPC_IDX_T0_CTRL);
	assign hit_t0n = addr_ok && (idx == `IPC_IDX_T0_COUNT);
	assign hit_any = hit_cap | hit_tmr | hit_rst | hit_main | hit_second | hit_third |
		hit_t0c | hit_t0n;

	always_comb begin
		rd_byte = 8'h00;
		if (hit_cap) begin
			rd_byte = s_q.cap_prio;
		end else if (hit_tmr) begin
			rd_byte = s_q.tmr_prio;
		end else if (hit_rst) begin
			rd_byte = s_q.rst_ctrl;
		end else if (hit_main) begin
			rd_byte = s_q.main_ctrl;
		end else if (hit_second) begin
			rd_byte = s_q.second_ctrl;
		end else if (hit_third) begin
			rd_byte = s_q.third_ctrl;
		end else if (hit_t0c) begin
			rd_byte = s_q.t0_ctrl;
		end
	end

	// ****************************************
	// Timer zero and request routing
	// ****************************************
	assign t0_wrap8 = s_q.t0_ctrl[`IPC_T0_RUN] & ~s_q.t0_ctrl[`IPC_T0_WIDE] &
		(s_q.t0_count[7:0] == 8'hff);
	assign t0_wrap16 = s_q.t0_ctrl[`IPC_T0_RUN] & s_q.t0_ctrl[`IPC_T0_WIDE] &
		(s_q.t0_count == 16'hffff);
	// A count write in the same cycle wins, so no wrap is seen then
	assign t0_wrap = (t0_wrap8 | t0_wrap16) & ~(wr & hit_t0n);

	// RULE_17: timer enable and priority
	assign core_act[0] = s_q.main_ctrl[`IPC_MAIN_T0_IF] & s_q.main_ctrl[`IPC_MAIN_T0_IE];
	assign core_prio[0] = s_q.second_ctrl[`IPC_SECOND_T0_IP];
	// RULE_14: pin zero fixed high
	assign core_act[1] = s_q.main_ctrl[`IPC_MAIN_X0_IF] & s_q.main_ctrl[`IPC_MAIN_X0_IE];
	assign core_prio[1] = 1'b1;
	// RULE_18: change enable and priority
	assign core_act[2] = s_q.main_ctrl[`IPC_MAIN_RB_IF] & s_q.main_ctrl[`IPC_MAIN_RB_IE];
	assign core_prio[2] = s_q.second_ctrl[`IPC_SECOND_RB_IP];
	// RULE_09: enable gates the pin request
	assign core_act[5:3] = s_q.third_ctrl[2:0] & s_q.third_ctrl[5:3];
	// RULE_13: pin one to three priorities
	assign core_prio[3] = s_q.third_ctrl[`IPC_THIRD_X1_IP];
	assign core_prio[4] = s_q.third_ctrl[`IPC_THIRD_X2_IP];
	assign core_prio[5] = s_q.second_ctrl[`IPC_SECOND_X3_IP];
	// RULE_01: capture channel selectors
	// RULE_02: enhanced channel selector
	// RULE_03: timer and comparator selectors
	assign periph_prio = {s_q.tmr_prio[5:0], s_q.cap_prio};
	assign any_core = |core_act;
	assign any_periph = |periph_pending;
	assign hi_pend = |(core_act & core_prio) | |(periph_pending & periph_prio);
	assign lo_pend = |(core_act & ~core_prio) | |(periph_pending & ~periph_prio);

	assign push = irq_taken & (s_q.sp != `IPC_STACK_DEPTH);
	assign pop = ret_pop & ~irq_taken & (s_q.sp != 5'd0);
	assign sp_less2 = s_q.sp - 5'd2;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_d = s_q;
		if (ce) begin
			if (setup) begin
				s_d.prdata = hit_t0n ? {16'h0000, s_q.t0_count} : {24'h000000, rd_byte};
				s_d.slverr = ~hit_any;
			end
			// RULE_01: capture selectors writable
			if (wr && hit_cap) begin
				s_d.cap_prio = pwdata[7:0];
			end
			// RULE_04: top bits masked off
			if (wr && hit_tmr) begin
				s_d.tmr_prio = pwdata[7:0] & `IPC_MASK_TMR_PRIO;
			end
			// RULE_05: priority enable writable
			// RULE_06: bit six never stored
			// RULE_07: watchdog and power-down bits read-only
			if (wr && hit_rst) begin
				s_d.rst_ctrl = (s_q.rst_ctrl & ~`IPC_MASK_RST_CTRL) |
					(pwdata[7:0] & `IPC_MASK_RST_CTRL);
			end
			// RULE_10: flags stay set until software writes them
			if (wr && hit_main) begin
				s_d.main_ctrl = pwdata[7:0];
			end
			if (wr && hit_second) begin
				s_d.second_ctrl = pwdata[7:0] & `IPC_MASK_SECOND_CTRL;
			end
			if (wr && hit_third) begin
				s_d.third_ctrl = pwdata[7:0];
			end
			if (wr && hit_t0c) begin
				s_d.t0_ctrl = pwdata[7:0] & `IPC_MASK_T0_CTRL;
			end
			if (wr && hit_t0n) begin
				s_d.t0_count = pwdata[15:0];
			end else if (s_q.t0_ctrl[`IPC_T0_RUN]) begin
				if (s_q.t0_ctrl[`IPC_T0_WIDE]) begin
					s_d.t0_count = s_q.t0_count + 16'h0001;
				end else begin
					s_d.t0_count[7:0] = s_q.t0_count[7:0] + 8'h01;
				end
			end
			// Hardware sets after the write, so a set in a clear cycle survives
			// RULE_15: eight-bit wrap flag
			// RULE_16: sixteen-bit wrap flag
			s_d.main_ctrl[`IPC_MAIN_T0_IF] = s_d.main_ctrl[`IPC_MAIN_T0_IF] | t0_wrap;
			// RULE_09: pin edges set flags
			s_d.main_ctrl[`IPC_MAIN_X0_IF] = s_d.main_ctrl[`IPC_MAIN_X0_IF] | ext_evt[0];
			s_d.third_ctrl[2:0] = s_d.third_ctrl[2:0] | ext_evt[3:1];
			// RULE_18: change flag set
			s_d.main_ctrl[`IPC_MAIN_RB_IF] = s_d.main_ctrl[`IPC_MAIN_RB_IF] | pb_change;

			// RULE_11: enables latched at power-managed entry
			s_d.pm_prev = sleep_mode | idle_mode;
			if ((sleep_mode | idle_mode) & ~s_q.pm_prev) begin
				s_d.wake_en = {s_q.third_ctrl[5:3], s_q.main_ctrl[`IPC_MAIN_X0_IE]};
			end
			s_d.wake = (sleep_mode | idle_mode) & s_q.pm_prev & |(ext_evt & s_q.wake_en);
			// RULE_12: only pin zero leaves deep sleep
			s_d.wake_reset = deep_sleep_mode & ext_evt[0];

			// RULE_05: two levels or single level
			// RULE_21: selectors ignored when levels off
			// RULE_22: routed request
			if (s_q.rst_ctrl[`IPC_RST_PRIO_EN]) begin
				s_d.irq_high = s_q.main_ctrl[`IPC_MAIN_GIE] & hi_pend;
				s_d.irq_low = s_q.main_ctrl[`IPC_MAIN_GIE] & s_q.main_ctrl[`IPC_MAIN_PEIE] &
					lo_pend;
			end else begin
				s_d.irq_high = s_q.main_ctrl[`IPC_MAIN_GIE] &
					(any_core | (s_q.main_ctrl[`IPC_MAIN_PEIE] & any_periph));
				s_d.irq_low = 1'b0;
			end

			// RULE_19: shadow context and return address
			if (irq_taken) begin
				s_d.sh_working_register = working_register_in;
				s_d.sh_status = status_in;
				s_d.sh_bsr = bank_select_register_in;
			end
			if (push) begin
				s_d.sp = s_q.sp + 5'd1;
				s_d.ret_pc = pc_in;
			end else if (pop) begin
				s_d.sp = s_q.sp - 5'd1;
				s_d.ret_pc = (s_q.sp >= 5'd2) ? stack_mem[sp_less2] : 21'h000000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.cap_prio <= `IPC_RST_CAP_PRIO;
			s_q.tmr_prio <= `IPC_RST_TMR_PRIO;
			s_q.rst_ctrl <= `IPC_RST_RST_CTRL;
			s_q.main_ctrl <= `IPC_RST_MAIN_CTRL;
			s_q.second_ctrl <= `IPC_RST_SECOND_CTRL;
			s_q.third_ctrl <= `IPC_RST_THIRD_CTRL;
			s_q.t0_ctrl <= `IPC_RST_T0_CTRL;
		end else begin
			s_q <= s_d;
		end
	end

	// Stack body needs no reset; depth pointer guards every read
	always_ff @(posedge pclk) begin
		if (ce && push) begin
			stack_mem[s_q.sp] <= pc_in;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata = s_q.prdata;
	assign pready = psel & penable & ce;
	assign pslverr = psel & penable & ce & s_q.slverr;
	assign irq_high = s_q.irq_high;
	assign irq_low = s_q.irq_low;
	assign wake_req = s_q.wake;
	assign wake_to_reset_vector = s_q.wake_reset;
	assign return_pc = s_q.ret_pc;
	assign shadow_working_register = s_q.sh_working_register;
	assign shadow_status = s_q.sh_status;
	assign shadow_bank_select = s_q.sh_bsr;
	assign stack_depth = s_q.sp;

	// ****************************************
	// Assertions
	// ****************************************
	property p_tmr_top_zero;
		@(posedge pclk) disable iff (!presetn)
		s_q.tmr_prio[7:6] == 2'h0;
	endproperty
	a_tmr_top_zero: assert property (p_tmr_top_zero) else $error("selector top bits set"); // RULE_04

	property p_rst_bit6_zero;
		@(posedge pclk) disable iff (!presetn)
		(ce && setup && hit_rst) |=> (prdata[6] == 1'b0);
	endproperty
	a_rst_bit6_zero: assert property (p_rst_bit6_zero) else $error("bit six read as one"); // RULE_06

	property p_pin_flag_set;
		@(posedge pclk) disable iff (!presetn)
		(ce && ext_evt[1]) |=> s_q.third_ctrl[`IPC_THIRD_X1_IF];
	endproperty
	a_pin_flag_set: assert property (p_pin_flag_set) else $error("pin flag not set"); // RULE_09

	property p_wrap8;
		@(posedge pclk) disable iff (!presetn)
		(ce && t0_wrap8 && !(wr && hit_t0n)) |=>
			(s_q.main_ctrl[`IPC_MAIN_T0_IF] && s_q.t0_count[7:0] == 8'h00);
	endproperty
	a_wrap8: assert property (p_wrap8) else $error("eight-bit wrap missed"); // RULE_15

	property p_wrap16;
		@(posedge pclk) disable iff (!presetn)
		(ce && t0_wrap16 && !(wr && hit_t0n)) |=>
			(s_q.main_ctrl[`IPC_MAIN_T0_IF] && s_q.t0_count == 16'h0000);
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("sixteen-bit wrap missed"); // RULE_16

	property p_change_flag;
		@(posedge pclk) disable iff (!presetn)
		(ce && pb_change) |=> s_q.main_ctrl[`IPC_MAIN_RB_IF];
	endproperty
	a_change_flag: assert property (p_change_flag) else $error("change flag not set"); // RULE_18

	property p_single_level;
		@(posedge pclk) disable iff (!presetn)
		(ce && !s_q.rst_ctrl[`IPC_RST_PRIO_EN]) |=> !irq_low;
	endproperty
	a_single_level: assert property (p_single_level) else $error("low request in single level"); // RULE_21

	property p_pin0_high;
		@(posedge pclk) disable iff (!presetn)
		(ce && s_q.rst_ctrl[`IPC_RST_PRIO_EN] && s_q.main_ctrl[`IPC_MAIN_GIE] && core_act[1])
			|=> irq_high;
	endproperty
	a_pin0_high: assert property (p_pin0_high) else $error("pin zero not high priority"); // RULE_14

	property p_deep_wake;
		@(posedge pclk) disable iff (!presetn)
		(ce && deep_sleep_mode && ext_evt[0]) |=> wake_to_reset_vector;
	endproperty
	a_deep_wake: assert property (p_deep_wake) else $error("deep sleep wake missed"); // RULE_12

	property p_ctx_save;
		@(posedge pclk) disable iff (!presetn)
		(ce && push) |=> (shadow_working_register == $past(working_register_in) &&
			return_pc == $past(pc_in) && stack_depth == $past(s_q.sp) + 5'd1);
	endproperty
	a_ctx_save: assert property (p_ctx_save) else $error("context not saved"); // RULE_19
endmodule

// File: src/ipc_map.svh
// Register map, field positions and reset values of the interrupt priority block.
// Assumes byte addresses are four times the register index; data in the low byte, or the low 16 bits for the timer-zero count.
`ifndef IPC_MAP_SVH
`define IPC_MAP_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define IPC_IDX_CAP_PRIO 12'hf90
`define IPC_IDX_TMR_PRIO 12'hf99
`define IPC_IDX_RST_CTRL 12'hfd0
`define IPC_IDX_MAIN_CTRL 12'h100
`define IPC_IDX_SECOND_CTRL 12'h101
`define IPC_IDX_THIRD_CTRL 12'h102
`define IPC_IDX_T0_CTRL 12'h103
`define IPC_IDX_T0_COUNT 12'h104

// ****************************************
// Reset values and write masks
// ****************************************
`define IPC_RST_CAP_PRIO 8'hff
`define IPC_RST_TMR_PRIO 8'h3f
`define IPC_MASK_TMR_PRIO 8'h3f
`define IPC_RST_RST_CTRL 8'h3c
`define IPC_MASK_RST_CTRL 8'hb3
`define IPC_RST_MAIN_CTRL 8'h00
`define IPC_RST_SECOND_CTRL 8'h7f
`define IPC_MASK_SECOND_CTRL 8'h7f
`define IPC_RST_THIRD_CTRL 8'hc0
`define IPC_RST_T0_CTRL 8'h00
`define IPC_MASK_T0_CTRL 8'h03

// ****************************************
// Field positions
// ****************************************
`define IPC_RST_PRIO_EN 7
`define IPC_MAIN_GIE 7
`define IPC_MAIN_PEIE 6
`define IPC_MAIN_T0_IE 5
`define IPC_MAIN_X0_IE 4
`define IPC_MAIN_RB_IE 3
`define IPC_MAIN_T0_IF 2
`define IPC_MAIN_X0_IF 1
`define IPC_MAIN_RB_IF 0
`define IPC_SECOND_EDGE0 6
`define IPC_SECOND_T0_IP 2
`define IPC_SECOND_X3_IP 1
`define IPC_SECOND_RB_IP 0
`define IPC_THIRD_X2_IP 7
`define IPC_THIRD_X1_IP 6
`define IPC_THIRD_X1_IE 3
`define IPC_THIRD_X1_IF 0
`define IPC_T0_RUN 0
`define IPC_T0_WIDE 1

// ****************************************
// Sizes
// ****************************************
`define IPC_STACK_DEPTH 5'd31

`endif

// File: src/ipc_pkg.sv
// Types shared by the interrupt priority block and its pin conditioner.
// Assumes the map header supplies all numeric constants.
package ipc_pkg;

	typedef struct packed {
		logic [7:0] cap_prio;
		logic [7:0] tmr_prio;
		logic [7:0] rst_ctrl;
		logic [7:0] main_ctrl;
		logic [7:0] second_ctrl;
		logic [7:0] third_ctrl;
		logic [7:0] t0_ctrl;
		logic [15:0] t0_count;
		logic [31:0] prdata;
		logic slverr;
		logic [3:0] wake_en;
		logic pm_prev;
		logic wake;
		logic wake_reset;
		logic irq_high;
		logic irq_low;
		logic [7:0] sh_working_register;
		logic [7:0] sh_status;
		logic [7:0] sh_bsr;
		logic [4:0] sp;
		logic [20:0] ret_pc;
	} ipc_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic stable;
		logic primed;
		logic [1:0] warm;
		logic rise;
		logic fall;
	} ipc_pin_t;

endpackage

// File: src/ipc_pin.sv
// Pin conditioner: three-stage synchroniser with agreement filter and edge pulses.
// Assumes an asynchronous pin; pulses are one pclk cycle wide while ce is high.
`timescale 1ns/100ps
module ipc_pin (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic pin,
	output logic stable,
	output logic rise,
	output logic fall
);
	ipc_pkg::ipc_pin_t s_q;
	ipc_pkg::ipc_pin_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.rise = 1'b0;
		s_d.fall = 1'b0;
		if (ce) begin
			s_d.s1 = pin;
			s_d.s2 = s_q.s1;
			s_d.s3 = s_q.s2;
			// Stages hold reset zeros, not pin samples, for three edges; an idle-high
			// pin would otherwise show a false rise after reset
			if (s_q.warm != 2'h3) begin
				s_d.warm = s_q.warm + 2'h1;
			// First real agreement only primes, so the idle level is no edge
			end else if (s_q.s2 == s_q.s3) begin
				s_d.stable = s_q.s3;
				s_d.primed = 1'b1;
				if (s_q.primed) begin
					s_d.rise = s_q.s3 & ~s_q.stable;
					s_d.fall = ~s_q.s3 & s_q.stable;
				end
			end
		end else begin
			s_d.rise = s_q.rise;
			s_d.fall = s_q.fall;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign stable = s_q.stable;
	assign rise = s_q.rise & ce;
	assign fall = s_q.fall & ce;
endmodule

// File: sim/ipc_core_model.sv
// Stand-in for the core and its service software: takes requests, supplies context.
// Assumes irq levels on pclk; accept and pop are levels from the bench.
`timescale 1ns/100ps
module ipc_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic irq_high,
	input wire logic irq_low,
	input wire logic accept,
	input wire logic pop,
	output logic irq_taken,
	output logic ret_pop,
	output logic [20:0] pc_in,
	output logic [7:0] working_register,
	output logic [7:0] status,
	output logic [7:0] bank_select_register
);
	logic taken_q;
	logic pop_q;
	logic [23:0] saved_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_taken <= 1'b0;
			ret_pop <= 1'b0;
			taken_q <= 1'b0;
			pop_q <= 1'b0;
			saved_q <= 24'h000000;
			pc_in <= 21'h1abcd;
			working_register <= 8'h5a;
			status <= 8'h13;
			bank_select_register <= 8'h0f;
		end else begin
			// One entry per accept window
			irq_taken <= accept && !taken_q && (irq_high || irq_low);
			taken_q <= accept && (taken_q || irq_high || irq_low);
			pop_q <= pop;
			ret_pop <= pop && !pop_q;
			if (irq_taken) begin
				saved_q <= {working_register, status, bank_select_register};
				// Context moves on, so late sampling shows up
				pc_in <= ~pc_in;
				working_register <= ~working_register;
				status <= ~status;
				bank_select_register <= ~bank_select_register;
			end
		end
	end
endmodule

// File: sim/tb.sv
// Bench for the interrupt priority block: APB register access, pins, timer, core traffic.
// Assumes the map header and the core stand-in; ce is held high throughout.
`timescale 1ns/100ps
`include "ipc_map.svh"
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin fail_count++; \
$display("mismatch t=%0t got=%h exp=%h", $time, (g), (x)); end end
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] ext_irq_pin, port_b_pin;
	logic [13:0] periph_pending;
	logic sleep_mode, idle_mode, deep_sleep_mode, irq_taken, ret_pop, accept, pop;
	logic irq_high, irq_low, wake_req, wake_to_reset_vector;
	logic [20:0] pc_in, return_pc;
	logic [7:0] working_register, status, bank_select_register, sh_w, sh_s, sh_b;
	logic [4:0] stack_depth;
	int checks, fail_count, wake_n, rstv_n;
	localparam logic [15:0] CAP = {2'b00, `IPC_IDX_CAP_PRIO, 2'b00};
	localparam logic [15:0] TMR = {2'b00, `IPC_IDX_TMR_PRIO, 2'b00};
	localparam logic [15:0] RST = {2'b00, `IPC_IDX_RST_CTRL, 2'b00};
	localparam logic [15:0] MAIN = {2'b00, `IPC_IDX_MAIN_CTRL, 2'b00};
	localparam logic [15:0] SEC = {2'b00, `IPC_IDX_SECOND_CTRL, 2'b00};
	localparam logic [15:0] THR = {2'b00, `IPC_IDX_THIRD_CTRL, 2'b00};
	localparam logic [15:0] T0C = {2'b00, `IPC_IDX_T0_CTRL, 2'b00};
	localparam logic [15:0] CNT = {2'b00, `IPC_IDX_T0_COUNT, 2'b00};

	ipc_top u_ipc_top (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
		.port_b_pin(port_b_pin), .periph_pending(periph_pending), .sleep_mode(sleep_mode),
		.idle_mode(idle_mode), .deep_sleep_mode(deep_sleep_mode), .irq_taken(irq_taken),
		.ret_pop(ret_pop), .pc_in(pc_in), .working_register_in(working_register), .status_in(status),
		.bank_select_register_in(bank_select_register), .irq_high(irq_high), .irq_low(irq_low),
		.wake_req(wake_req), .wake_to_reset_vector(wake_to_reset_vector),
		.return_pc(return_pc), .shadow_working_register(sh_w), .shadow_status(sh_s),
		.shadow_bank_select(sh_b), .stack_depth(stack_depth));
	ipc_core_model u_ipc_core_model (.pclk(pclk), .presetn(presetn), .irq_high(irq_high),
		.irq_low(irq_low), .accept(accept), .pop(pop), .irq_taken(irq_taken),
		.ret_pop(ret_pop), .pc_in(pc_in), .working_register(working_register), .status(status), .bank_select_register(bank_select_register));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Wake pulses last one cycle, so count them
	always @(posedge pclk) begin
		if (wake_req === 1'b1)
			wake_n++;
		if (wake_to_reset_vector === 1'b1)
			rstv_n++;
	end

	task automatic summarize;
		$display("checks=%0d mismatches=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Idle edge first, so strobes are never assigned twice in one step
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100)
			fail_count++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
		`CHK({e, r}, {1'b0, x})
	endtask

	task automatic irq_is(input logic [1:0] x);
		repeat (3) @(posedge pclk);
		`CHK({irq_high, irq_low}, x)
	endtask

	initial begin
		#300000;
		fail_count++;
		summarize();
	end

	initial begin
		logic [31:0] r;
		logic e;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ext_irq_pin, port_b_pin, periph_pending} = '0;
		{sleep_mode, idle_mode, deep_sleep_mode, accept, pop} = '0;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(CAP, 32'hff);
		rd(TMR, 32'h3f);
		rd(RST, 32'h3c);
		rd(SEC, 32'h7f);
		rd(THR, 32'hc0);
		wr(CAP, 32'ha5);
		rd(CAP, 32'ha5);
		wr(TMR, 32'hff);
		rd(TMR, 32'h3f);
		wr(RST, 32'hff);
		rd(RST, 32'hbf);
		wr(RST, 32'h00);
		rd(RST, 32'h0c);
		apb(1'b1, 16'h8000, 32'hff, r, e);
		`CHK({e, r}, {1'b1, 32'h0})
		apb(1'b0, 16'h0402, 32'h0, r, e);
		`CHK({e, r}, {1'b1, 32'h0})
		// Peripheral routing, single level then split
		wr(CAP, 32'h00);
		wr(MAIN, 32'hc0);
		periph_pending <= 14'h0001;
		irq_is(2'b10);
		wr(RST, 32'h80);
		irq_is(2'b01);
		periph_pending <= 14'h2000;
		wr(TMR, 32'h20);
		irq_is(2'b10);
		wr(TMR, 32'h00);
		irq_is(2'b01);
		periph_pending <= 14'h0000;
		// Pin one, rising edge selected
		wr(SEC, 32'h60);
		wr(THR, 32'h08);
		ext_irq_pin[1] <= 1'b1;
		repeat (10) @(posedge pclk);
		rd(THR, 32'h09);
		irq_is(2'b01);
		wr(THR, 32'h49);
		irq_is(2'b10);
		wr(THR, 32'h00);
		ext_irq_pin[1] <= 1'b0;
		repeat (10) @(posedge pclk);
		rd(THR, 32'h00);
		wr(THR, 32'h00);
		// Pin zero flag while disabled, then enabled
		ext_irq_pin[0] <= 1'b1;
		repeat (10) @(posedge pclk);
		rd(MAIN, 32'hc2);
		irq_is(2'b00);
		wr(MAIN, 32'hd2);
		irq_is(2'b10);
		accept <= 1'b1;
		repeat (4) @(posedge pclk);
		`CHK({return_pc, sh_w, sh_s, sh_b}, {21'h1abcd, 24'h5a130f})
		`CHK(stack_depth, 5'd1)
		`CHK(u_ipc_core_model.saved_q, 24'h5a130f)
		accept <= 1'b0;
		wr(MAIN, 32'h00);
		pop <= 1'b1;
		repeat (3) @(posedge pclk);
		pop <= 1'b0;
		`CHK({stack_depth, return_pc}, {5'd0, 21'h0})
		// Timer zero, narrow then wide
		wr(CNT, 32'hfd);
		wr(T0C, 32'h01);
		repeat (8) @(posedge pclk);
		rd(MAIN, 32'h04);
		wr(T0C, 32'h00);
		wr(MAIN, 32'h00);
		wr(CNT, 32'hfd);
		wr(T0C, 32'h03);
		repeat (8) @(posedge pclk);
		rd(MAIN, 32'h00);
		wr(CNT, 32'hfffd);
		repeat (8) @(posedge pclk);
		rd(MAIN, 32'h04);
		wr(T0C, 32'h00);
		wr(MAIN, 32'h00);
		// Port-B change
		port_b_pin[3] <= 1'b1;
		repeat (10) @(posedge pclk);
		rd(MAIN, 32'h01);
		wr(MAIN, 32'hc9);
		irq_is(2'b01);
		wr(MAIN, 32'h00);
		// Wake: enabled before entry, then enabled only after entry
		wr(THR, 32'h08);
		sleep_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		ext_irq_pin[1] <= 1'b1;
		repeat (10) @(posedge pclk);
		`CHK(wake_n, 1)
		sleep_mode <= 1'b0;
		ext_irq_pin[1] <= 1'b0;
		wr(THR, 32'h00);
		idle_mode <= 1'b1;
		wr(THR, 32'h08);
		ext_irq_pin[1] <= 1'b1;
		repeat (10) @(posedge pclk);
		`CHK(wake_n, 1)
		idle_mode <= 1'b0;
		ext_irq_pin[0] <= 1'b0;
		repeat (8) @(posedge pclk);
		deep_sleep_mode <= 1'b1;
		repeat (2) @(posedge pclk);
		ext_irq_pin[0] <= 1'b1;
		repeat (10) @(posedge pclk);
		`CHK(rstv_n, 1)
		summarize();
	end
endmodule
